//--- aoi_pkg.sv
package aoi_pkg;
   // -----------------------------------------------------------------
   // Summary of operation
   // R01: Software refills four samples per request
   // R02: Software sets master clock 256 or 384 Fs
   // R03: Polarity bit picks left channel word-select level
   // R04: Size bit picks 32 or 16 bit slots
   // R05: Rate bit sets bit clock for 384/256 Fs
   // R06: Justify field shifts data start in frame
   // R07: 00000 MSB, 10000 LSB, 00001 I2S, zero fill
   // R08: Source bit picks processor or decoder stream
   // R09: Request enable bit asks decoder for data
   // R10: Request mask blocks sample-request interrupt
   // R11: Under-run mask blocks under-run interrupt
   // R12: Bit three reserved, reads zero, never set
   // R13: Repeat field sets processor sample repetition
   // R14: Codes give 1, 2, 4, 6 repeats
   // R15: Enable bit turns the interface on
   // R16: Request flag at half empty, cleared by writes
   // R17: Eight-byte buffer, flag on 4-3, off 4-5
   // R18: Under-run flag on empty, cleared by writes
   // R19: Busy flag while buffer is full
   // R20: Status read-only, low five bits zero
   // R21: Data register write pushes one sample byte
   // R22: Sample widened with zero low byte
   // R23: Five-bit divider makes master clock from PLL; here it divides sys_clk
   // R24: Software answers requests in time
   // R25: Interrupt is OR of unmasked flags, gated
   // -----------------------------------------------------------------

   // -----------------------------------------------------------------
   // Register addresses
   // -----------------------------------------------------------------
   localparam logic [7:0] aoi_addr_format  = 8'h9A;
   localparam logic [7:0] aoi_addr_source  = 8'h9B;
   localparam logic [7:0] aoi_addr_status  = 8'h9C;
   localparam logic [7:0] aoi_addr_data    = 8'h9D;
   localparam logic [7:0] aoi_addr_clkdiv  = 8'hEC;

   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [7:0] aoi_rst_format   = 8'h00;
   localparam logic [7:0] aoi_rst_source   = 8'hB2;
   localparam logic [7:0] aoi_rst_data     = 8'hFF;
   localparam logic [7:0] aoi_rst_clkdiv   = 8'h00;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int aoi_f_just_hi   = 7;
   localparam int aoi_f_just_lo   = 3;
   localparam int aoi_f_pol       = 2;
   localparam int aoi_f_dsize     = 1;
   localparam int aoi_f_rate      = 0;
   localparam int aoi_f_src       = 7;
   localparam int aoi_f_dreq      = 6;
   localparam int aoi_f_mreq      = 5;
   localparam int aoi_f_mudr      = 4;
   localparam int aoi_f_rsvd      = 3;
   localparam int aoi_f_dup_hi    = 2;
   localparam int aoi_f_dup_lo    = 1;
   localparam int aoi_f_en        = 0;
   localparam int aoi_f_sample_request_flag      = 7;
   localparam int aoi_f_underrun_flag      = 6;
   localparam int aoi_f_busy      = 5;
   localparam int aoi_f_cdiv_hi   = 4;

   // -----------------------------------------------------------------
   // Buffer and timing
   // -----------------------------------------------------------------
   localparam int         aoi_buf_depth  = 8;
   localparam logic [3:0] aoi_req_level  = 4'h4;
   localparam logic [8:0] aoi_mclk_per_fs_lo = 9'h100;  // 256 Fs
   localparam logic [8:0] aoi_mclk_per_fs_hi = 9'h180;  // 384 Fs
   localparam logic [2:0] aoi_rep_x1 = 3'h1;
   localparam logic [2:0] aoi_rep_x2 = 3'h2;
   localparam logic [2:0] aoi_rep_x4 = 3'h4;
   localparam logic [2:0] aoi_rep_x6 = 3'h6;

   // Serializer states
   typedef enum logic [2:0] {
      aoi_st_idle  = 3'b001,
      aoi_st_load  = 3'b010,
      aoi_st_shift = 3'b100
   } aoi_state_type;
endpackage

//--- aoi_clkdiv.sv
// -----------------------------------------------------------------
// Programmable divider: toggles out every (div+1) input cycles
// -----------------------------------------------------------------
module aoi_clkdiv (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       run,
   input  wire logic [4:0] div,
   output logic            tick,
   output logic            clk_out
);
   logic [4:0] cnt_q;
   logic       out_q;

   assign tick    = run && (cnt_q == div);
   assign clk_out = out_q;

   // Count up to the divider value, then toggle the output level
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 5'h00;
         out_q <= 1'b0;
      end else if (!run) begin
         cnt_q <= 5'h00;
         out_q <= 1'b0;
      end else if (tick) begin
         cnt_q <= 5'h00;
         out_q <= ~out_q;
      end else begin
         cnt_q <= cnt_q + 5'h01;
      end
   end
endmodule

//--- aoi_top.sv
module aoi_top (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        pll_tick,
   input  wire logic [7:0]  sfr_addr,
   input  wire logic [7:0]  sfr_wdata,
   input  wire logic        sfr_wr,
   input  wire logic        sfr_rd,
   output logic      [7:0]  sfr_rdata,
   input  wire logic        interrupt_enable_reg,
   output logic             audio_irq,
   input  wire logic [15:0] dec_data,
   input  wire logic        dec_valid,
   output logic             dec_request,
   output logic             master_clk_out,
   output logic             bit_clock_out,
   output logic             word_select_out,
   output logic             serial_data_out
);
   // -----------------------------------------------------------------
   // Control registers
   // -----------------------------------------------------------------
   logic [7:0] fmt_q, src_q, dat_q, cdiv_q;
   logic       sample_request_flag_q, underrun_flag_q;

   wire wr_fmt  = sfr_wr && (sfr_addr == aoi_pkg::aoi_addr_format);
   wire wr_src  = sfr_wr && (sfr_addr == aoi_pkg::aoi_addr_source);
   wire wr_dat  = sfr_wr && (sfr_addr == aoi_pkg::aoi_addr_data);
   wire wr_cdiv = sfr_wr && (sfr_addr == aoi_pkg::aoi_addr_clkdiv);

   wire [4:0] justify_offset     = fmt_q[aoi_pkg::aoi_f_just_hi:aoi_pkg::aoi_f_just_lo];
   wire       left_channel_level = fmt_q[aoi_pkg::aoi_f_pol];
   wire       slot_width_sel     = fmt_q[aoi_pkg::aoi_f_dsize];
   wire       master_rate_sel    = fmt_q[aoi_pkg::aoi_f_rate];
   wire       stream_source_sel  = src_q[aoi_pkg::aoi_f_src];
   wire       decoder_request_enable = src_q[aoi_pkg::aoi_f_dreq];
   wire       request_irq_mask   = src_q[aoi_pkg::aoi_f_mreq];
   wire       underrun_irq_mask  = src_q[aoi_pkg::aoi_f_mudr];
   wire [1:0] repeat_factor      = src_q[aoi_pkg::aoi_f_dup_hi:aoi_pkg::aoi_f_dup_lo];
   wire       audio_if_enable    = src_q[aoi_pkg::aoi_f_en];
   wire [4:0] master_clock_div   = cdiv_q[aoi_pkg::aoi_f_cdiv_hi:0];

   // Register writes; reserved bits are forced to zero
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         fmt_q  <= aoi_pkg::aoi_rst_format;
         src_q  <= aoi_pkg::aoi_rst_source;
         dat_q  <= aoi_pkg::aoi_rst_data;
         cdiv_q <= aoi_pkg::aoi_rst_clkdiv;
      end else begin
         if (wr_fmt)  fmt_q  <= sfr_wdata;   // R06
         if (wr_src)  src_q  <= sfr_wdata & 8'hF7;   // R12
         if (wr_dat)  dat_q  <= sfr_wdata;   // R21
         if (wr_cdiv) cdiv_q <= {3'h0, sfr_wdata[4:0]};   // R23
      end
   end

   // -----------------------------------------------------------------
   // Sample buffer for processor bytes
   // -----------------------------------------------------------------
   logic [7:0] buf_mem [aoi_pkg::aoi_buf_depth];
   logic [2:0] wp_q, rp_q;
   logic [3:0] cnt_q;
   logic       pop;

   wire proc_mode = stream_source_sel && audio_if_enable;   // R08
   wire buf_full  = (cnt_q == 4'h8);
   wire push      = wr_dat && proc_mode && !buf_full;   // R21
   wire pop_ok    = pop && (cnt_q != 4'h0);
   wire [3:0] cnt_d = cnt_q + {3'h0, push} - {3'h0, pop_ok};

   // Pointer and level bookkeeping; writes beyond full are dropped
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wp_q  <= 3'h0;
         rp_q  <= 3'h0;
         cnt_q <= 4'h0;
      end else if (!proc_mode) begin
         wp_q  <= 3'h0;
         rp_q  <= 3'h0;
         cnt_q <= 4'h0;
      end else begin
         if (push)   wp_q <= wp_q + 3'h1;
         if (pop_ok) rp_q <= rp_q + 3'h1;
         cnt_q <= cnt_d;   // R17
      end
   end

   // Storage array; no reset needed for data contents
   always_ff @(posedge sys_clk) begin
      if (push) buf_mem[wp_q] <= sfr_wdata;
   end

   // -----------------------------------------------------------------
   // Status flags; a write in the same cycle as a pop cancels the set
   // -----------------------------------------------------------------
   wire sample_request_flag_set = pop_ok && !push && (cnt_q == aoi_pkg::aoi_req_level);   // R17
   wire underrun_flag_set = pop_ok && !push && (cnt_q == 4'h1);   // R18
   wire sample_request_flag_clr = push && !pop_ok && (cnt_q == aoi_pkg::aoi_req_level);   // R16

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sample_request_flag_q <= 1'b0;
         underrun_flag_q <= 1'b0;
      end else if (!proc_mode) begin
         sample_request_flag_q <= 1'b0;
         underrun_flag_q <= 1'b0;
      end else begin
         if (sample_request_flag_set)      sample_request_flag_q <= 1'b1;   // R16
         else if (sample_request_flag_clr) sample_request_flag_q <= 1'b0;
         if (underrun_flag_set)      underrun_flag_q <= 1'b1;   // R18
         else if (push)     underrun_flag_q <= 1'b0;
      end
   end

   wire busy = proc_mode && buf_full;   // R19
   wire [7:0] status_val = {sample_request_flag_q, underrun_flag_q, busy, 5'h00};   // R20

   // Interrupt: unmasked flags gated by global enable
   assign audio_irq = interrupt_enable_reg &&
                      ((sample_request_flag_q && !request_irq_mask) ||   // R10
                       (underrun_flag_q && !underrun_irq_mask));   // R11 R25

   // Read mux; unmapped addresses read zero
   assign sfr_rdata = !sfr_rd ? 8'h00 :
                      (sfr_addr == aoi_pkg::aoi_addr_format) ? fmt_q :
                      (sfr_addr == aoi_pkg::aoi_addr_source) ? src_q :
                      (sfr_addr == aoi_pkg::aoi_addr_status) ? status_val :
                      (sfr_addr == aoi_pkg::aoi_addr_data)   ? dat_q :
                      (sfr_addr == aoi_pkg::aoi_addr_clkdiv) ? cdiv_q : 8'h00;

   // -----------------------------------------------------------------
   // Master clock from sys_clk through the 5-bit divider; the PLL tick gates only the serializer's edge strobe, not master_clk_out
   // -----------------------------------------------------------------
   logic mclk_tick_raw, mclk_lvl;
   aoi_clkdiv u_mdiv (
      .sys_clk (sys_clk),
      .rst     (rst),
      .run     (audio_if_enable),   // R15
      .div     (master_clock_div),   // R23
      .tick    (mclk_tick_raw),
      .clk_out (mclk_lvl)
   );
   wire mclk_edge = mclk_tick_raw && pll_tick && mclk_lvl;   // R23
   assign master_clk_out = mclk_lvl;

   // -----------------------------------------------------------------
   // Bit clock: master clocks per frame split over 2 x slot bits
   // -----------------------------------------------------------------
   // Half bit period in master clocks: 256Fs/64bits=4 -> 2, 384/64=6 -> 3
   wire [4:0] slot_bits = slot_width_sel ? 5'd31 : 5'd15;   // R04
   wire [3:0] half_bit  = master_rate_sel ?                  // R05
                          (slot_width_sel ? 4'd3 : 4'd6) :   // 384/64=6 -> 3, 384/32=12 -> 6
                          (slot_width_sel ? 4'd2 : 4'd4);    // 256/64=4 -> 2, 256/32=8 -> 4
   logic [3:0] hb_q;
   logic       bclk_q, wsel_q, sdo_q;
   logic [4:0] bit_q;
   logic [15:0] left_q, right_q;
   logic [2:0]  rep_q;
   aoi_pkg::aoi_state_type st_q;

   wire bclk_fall = mclk_edge && (hb_q == half_bit - 4'd1) && bclk_q;
   wire slot_end  = bclk_fall && (bit_q == slot_bits);
   wire frame_end = slot_end && (wsel_q != left_channel_level);

   wire [2:0] rep_limit = (repeat_factor == 2'b00) ? aoi_pkg::aoi_rep_x1 :   // R14
                          (repeat_factor == 2'b01) ? aoi_pkg::aoi_rep_x2 :
                          (repeat_factor == 2'b10) ? aoi_pkg::aoi_rep_x4 :
                                                     aoi_pkg::aoi_rep_x6;   // R13
   wire avail = proc_mode ? (cnt_q != 4'h0) : dec_valid;
   wire [15:0] next_word = proc_mode ? {buf_mem[rp_q], 8'h00} : dec_data;   // R08 R22
   wire need_new = (rep_q == 3'h0) || (rep_q == rep_limit);
   assign pop = (st_q == aoi_pkg::aoi_st_load) && need_new;

   // Bit for the next rising edge: data moves on the falling bit clock, so the
   // converter never samples a changing line; low bits beyond the word are zero
   wire [4:0] nxt_bit = slot_end ? 5'h00 : bit_q + 5'h01;
   wire       nxt_ws  = slot_end ? ~wsel_q : wsel_q;
   wire [5:0] rel = {1'b0, nxt_bit} - {1'b0, justify_offset};   // R06
   wire in_data = (nxt_bit >= justify_offset) && (rel < 6'd16);   // R07
   wire [15:0] cur = (nxt_ws == left_channel_level) ? left_q : right_q;   // R03
   // First bit of a frame is set up while the word loads
   wire [15:0] load_word = need_new ? next_word : left_q;
   wire        first_bit = (justify_offset == 5'h00) && load_word[15];   // R07
   wire bit_val = in_data ? cur[4'd15 - rel[3:0]] : 1'b0;

   assign dec_request = audio_if_enable && !stream_source_sel && decoder_request_enable;   // R09

   // Serializer sequence
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_q    <= aoi_pkg::aoi_st_idle;
         hb_q    <= 4'h0;
         bclk_q  <= 1'b0;
         wsel_q  <= 1'b0;
         bit_q   <= 5'h00;
         left_q  <= 16'h0000;
         right_q <= 16'h0000;
         rep_q   <= 3'h0;
         sdo_q   <= 1'b0;
      end else if (!audio_if_enable) begin
         st_q   <= aoi_pkg::aoi_st_idle;   // R15
         bclk_q <= 1'b0;
         rep_q  <= 3'h0;
         sdo_q  <= 1'b0;
      end else begin
         unique case (st_q)
            aoi_pkg::aoi_st_idle: begin
               bclk_q <= 1'b0;
               wsel_q <= left_channel_level;   // R03
               if (avail || (rep_q != 3'h0 && !need_new)) st_q <= aoi_pkg::aoi_st_load;
            end
            aoi_pkg::aoi_st_load: begin
               if (need_new) begin
                  left_q  <= next_word;
                  right_q <= next_word;
                  rep_q   <= 3'h1;
               end else begin
                  rep_q <= rep_q + 3'h1;   // R13
               end
               bit_q <= 5'h00;
               hb_q  <= 4'h0;
               sdo_q <= first_bit;
               st_q  <= aoi_pkg::aoi_st_shift;
            end
            aoi_pkg::aoi_st_shift: begin
               if (mclk_edge) begin
                  if (hb_q == half_bit - 4'd1) begin   // R05
                     hb_q   <= 4'h0;
                     bclk_q <= ~bclk_q;
                     if (bclk_q) sdo_q <= bit_val;   // Falling edge
                  end else begin
                     hb_q <= hb_q + 4'h1;
                  end
               end
               if (bclk_fall) bit_q <= bit_q + 5'h01;
               if (slot_end) begin
                  bit_q  <= 5'h00;
                  wsel_q <= ~wsel_q;
               end
               if (frame_end) begin
                  if (!need_new || avail) st_q <= aoi_pkg::aoi_st_load;
                  else st_q <= aoi_pkg::aoi_st_idle;   // bit clock stops without data
               end
            end
            default: st_q <= aoi_pkg::aoi_st_idle;
         endcase
      end
   end

   assign bit_clock_out   = bclk_q;
   assign word_select_out = wsel_q;
   assign serial_data_out = sdo_q;
endmodule

//--- aoi_dac_model.sv
// -----------------------------------------------------------------
// Converter model: shifts in data on the rising bit clock edge
// -----------------------------------------------------------------
module aoi_dac_model (
   input wire logic bclk,
   input wire logic ws,
   input wire logic sdata,
   input wire logic left_lvl
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        ws_q;
   logic [15:0] sh;
   int unsigned cnt = 0;
   int unsigned slot_bits = 0;
   logic [15:0] left_word;
   bit          got_left = 0;
   int unsigned frames = 0;

   // Forgets what was seen, so a new format is observed from its start
   task automatic rearm;
      ws_q     = 1'bx;
      cnt      = 0;
      frames   = 0;
      got_left = 0;
   endtask

   // A word-select change closes a slot; only the first left word is kept
   always @(posedge bclk) begin
      if (ws !== ws_q) begin
         if (ws_q === left_lvl) frames++;
         if (ws_q === left_lvl && !got_left) begin
            left_word = sh;
            slot_bits = cnt;
            got_left  = 1;
         end
         cnt  = 0;
         ws_q = ws;
      end
      if (cnt < 16) sh = {sh[14:0], sdata};
      cnt++;
   end
endmodule

//--- aoi_top_props.sv
// -----------------------------------------------------------------
// Port checker
// -----------------------------------------------------------------
module aoi_top_props (
   input wire logic       sys_clk,
   input wire logic       rst,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic       sfr_wr,
   input wire logic       sfr_rd,
   input wire logic [7:0] sfr_rdata,
   input wire logic       interrupt_enable_reg,
   input wire logic       audio_irq,
   input wire logic       dec_request,
   input wire logic       master_clk_out,
   input wire logic       bit_clock_out,
   input wire logic       word_select_out
);
   logic [7:0] src_q;
   wire        src_wr = sfr_wr && sfr_addr == aoi_pkg::aoi_addr_source;
   wire        st_rd  = sfr_rd && sfr_addr == aoi_pkg::aoi_addr_status;
   wire        mapped = sfr_addr inside {aoi_pkg::aoi_addr_format, aoi_pkg::aoi_addr_source,
      aoi_pkg::aoi_addr_status, aoi_pkg::aoi_addr_data, aoi_pkg::aoi_addr_clkdiv};

   // Shadow of the source control register, so masks are known here
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) src_q <= aoi_pkg::aoi_rst_source;
      else if (src_wr) src_q <= sfr_wdata;
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   irq_gate_a: assert property (st_rd |-> audio_irq == (interrupt_enable_reg &&
      ((sfr_rdata[7] && !src_q[5]) || (sfr_rdata[6] && !src_q[4]))))
      else $error("irq not the gated or of flags");
   stat_low_a: assert property (st_rd |-> sfr_rdata[4:0] == 5'h00)
      else $error("status low bits not zero");
   rsvd_zero_a: assert property (sfr_rd && sfr_addr == aoi_pkg::aoi_addr_source
      |-> !sfr_rdata[3]) else $error("reserved source bit reads one");
   div_high_a: assert property (sfr_rd && sfr_addr == aoi_pkg::aoi_addr_clkdiv
      |-> sfr_rdata[7:5] == 3'h0) else $error("divider high bits not zero");
   unmapped_zero_a: assert property (!(sfr_rd && mapped) |-> sfr_rdata == 8'h00)
      else $error("read data not zero");
   dec_req_a: assert property (!src_wr ##1 !src_wr
      |-> dec_request == (src_q[0] && src_q[6] && !src_q[7]))
      else $error("decoder request wrong");
   mp3_flags_a: assert property (st_rd && !src_q[7] && $stable(src_q)
      |-> sfr_rdata[7:5] == 3'h0) else $error("flags set in decoder mode");
   idle_off_a: assert property ((!src_q[0]) [*4] |-> $stable(bit_clock_out)
      && $stable(word_select_out) && $stable(master_clk_out))
      else $error("clocks run while disabled");

   irq_c: cover property ($rose(audio_irq));
   dreq_c: cover property ($rose(dec_request));
   busy_c: cover property (st_rd && sfr_rdata[5]);
endmodule

bind aoi_top aoi_top_props i_props (.sys_clk, .rst, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd,
   .sfr_rdata, .interrupt_enable_reg, .audio_irq, .dec_request, .master_clk_out,
   .bit_clock_out, .word_select_out);

//--- audio_output_interface_test.sv
module audio_output_interface_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic       sys_clk, rst, pll_tick, sfr_wr, sfr_rd, ie, irq, dreq, mclk, bclk, ws, sd;
   logic [7:0] addr, wdata, rdata, v;
   logic       lvl = 1'b1;
   int         fails = 0;
   int         checks_done = 0;

   aoi_top i_dut (.sys_clk(sys_clk), .rst(rst), .pll_tick(pll_tick), .sfr_addr(addr),
      .sfr_wdata(wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(rdata),
      .interrupt_enable_reg(ie), .audio_irq(irq), .dec_data(16'h1234), .dec_valid(1'b1),
      .dec_request(dreq), .master_clk_out(mclk), .bit_clock_out(bclk),
      .word_select_out(ws), .serial_data_out(sd));
   // Left channel level follows the polarity bit that each scenario sets
   aoi_dac_model i_dac (.bclk(bclk), .ws(ws), .sdata(sd), .left_lvl(lvl));

   // -----------------------------------------------------------------
   // Bus and compare tasks
   // -----------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      addr = a;
      wdata = d;
      sfr_wr = 1;
      @(negedge sys_clk);
      sfr_wr = 0;
   endtask
   // Read data is combinational; it is taken at the rising edge, half a cycle before the falling edge that closes the read
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      addr = a;
      sfr_rd = 1;
      @(posedge sys_clk);
      d = rdata;
      @(negedge sys_clk);
      sfr_rd = 0;
   endtask
   task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      checks_done++;
      if (d !== e) begin
         fails++;
         $display("ERROR %0t read %h got %h want %h", $time, a, d, e);
      end
   endtask
   task automatic cmp_bit(input logic g, input logic e);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("ERROR %0t flag got %b want %b", $time, g, e);
      end
   endtask
   task automatic cmp_val(input logic [15:0] g, input logic [15:0] e);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("ERROR %0t value got %h want %h", $time, g, e);
      end
   endtask
   // Polls status until the chosen bit rises, bounded so a dead buffer cannot hang
   task automatic wait_stat(input int b);
      for (int n = 0; n < 20000; n++) begin
         rd(8'h9C, v);
         if (v[b] === 1'b1) break;
      end
   endtask

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic t_reset;
      chk_rd(8'h9A, 8'h00);
      chk_rd(8'h9B, 8'hB2);
      chk_rd(8'h9C, 8'h00);
      chk_rd(8'h9D, 8'hFF);
      chk_rd(8'hEC, 8'h00);
      chk_rd(8'h55, 8'h00);
      $display("reset test done");
   endtask
   task automatic t_regs;
      wr(8'hEC, 8'hFF);
      chk_rd(8'hEC, 8'h1F);
      wr(8'h9B, 8'hBA);
      chk_rd(8'h9B, 8'hB2);
      wr(8'h9A, 8'h5A);
      chk_rd(8'h9A, 8'h5A);
      wr(8'h9D, 8'h3C);
      chk_rd(8'h9D, 8'h3C);
      wr(8'hEC, 8'h00);
      $display("register test done");
   endtask
   task automatic t_voice;
      // Clock enable held off so only the first byte is drained while the buffer fills
      pll_tick = 0;
      wr(8'h9A, 8'h06);
      wr(8'h9B, 8'h81);
      ie = 1;
      for (int i = 0; i < 9; i++) wr(8'h9D, 8'hA0 + i[7:0]);
      chk_rd(8'h9C, 8'h20);
      pll_tick = 1;
      wait_stat(7);
      cmp_bit(v[7], 1);
      cmp_bit(irq, 1);
      wr(8'h9B, 8'hA1);
      cmp_bit(irq, 0);
      wr(8'h9D, 8'h21);
      wr(8'h9D, 8'h22);
      chk_rd(8'h9C, 8'h00);
      wait_stat(6);
      cmp_bit(v[6], 1);
      cmp_bit(irq, 1);
      wr(8'h9B, 8'hB1);
      cmp_bit(irq, 0);
      wr(8'h9D, 8'h11);
      rd(8'h9C, v);
      cmp_bit(v[6], 0);
      cmp_val(i_dac.left_word, 16'hA000);
      cmp_val(i_dac.slot_bits[15:0], 16'h0020);
      wr(8'h9B, 8'h80);
      $display("voice test done");
   endtask
   task automatic t_i2s;
      // Left channel low, 16-bit slots, data one bit late, each byte sent twice
      pll_tick = 0;
      wr(8'h9A, 8'h08);
      lvl = 0;
      i_dac.rearm();
      wr(8'h9B, 8'h83);
      for (int i = 0; i < 4; i++) wr(8'h9D, 8'hB5);
      pll_tick = 1;
      wait_stat(6);
      cmp_bit(v[6], 1);
      repeat (1200) @(negedge sys_clk);
      cmp_val(i_dac.left_word, 16'h5A80);
      cmp_val(i_dac.slot_bits[15:0], 16'h0010);
      cmp_val(i_dac.frames[15:0], 16'h0008);
      wr(8'h9B, 8'h80);
      $display("i2s test done");
   endtask
   task automatic t_mp3;
      wr(8'h9B, 8'h41);
      repeat (2) @(negedge sys_clk);
      cmp_bit(dreq, 1);
      chk_rd(8'h9C, 8'h00);
      wr(8'h9B, 8'h01);
      repeat (2) @(negedge sys_clk);
      cmp_bit(dreq, 0);
      wr(8'h9B, 8'hC1);
      repeat (2) @(negedge sys_clk);
      cmp_bit(dreq, 0);
      $display("decoder test done");
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // -----------------------------------------------------------------
   // Clock, reset, sequence and watchdog
   // -----------------------------------------------------------------
   initial begin
      sys_clk = 0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   initial begin
      {rst, pll_tick, sfr_wr, sfr_rd, ie, addr, wdata} = {5'h11, 16'h0000};
      repeat (20) @(posedge sys_clk);
      @(negedge sys_clk);
      rst = 0;
      t_reset();
      t_regs();
      t_voice();
      t_i2s();
      t_mp3();
      wrap_up();
   end
   // Fill and drain take some thousands of cycles; this leaves ample margin
   initial begin
      #(90000 * 25);
      fails++;
      wrap_up();
   end
endmodule
